/* File: port_expander_consts.svh */
`ifndef PORT_EXPANDER_CONSTS_SVH
`define PORT_EXPANDER_CONSTS_SVH
// Summary of operation
// - D0 enables blink; D1 picks phase
// - D2 set: outputs use master intensity nibble
// - D2 clear: per-port intensity; extra pin master
// - D3 set: shared pin is change alert
// - D3 clear: shared pin uses D4/D5 only
// - no blink: D4 low drives, high floats
// - blink phase 0: pin follows D4
// - blink phase 1: pin follows D5
// - D7 shows change; alert pin low then if D3 set
// - D6 reads zero; D7/D6 writes ignored
// - direction bit 1 input, 0 output
// - direction registers read back last write
// - change clears on return or on a read of the changed port byte
// - configuration resets to 0x0C

// =====================================================================
// register addresses
`define ADDR_DIR_LOW      8'h06
`define ADDR_DIR_HIGH     8'h07
`define ADDR_DEV_CTRL     8'h0F

// =====================================================================
// device control field positions
`define BIT_BLINK_EN      0
`define BIT_BLINK_PHASE   1
`define BIT_GLOBAL_INT    2
`define BIT_ALERT_EN      3
`define BIT_LEVEL0        4
`define BIT_LEVEL1        5
`define BIT_ZERO          6
`define BIT_CHANGE        7

// =====================================================================
// reset values
`define RESET_DEV_CTRL    8'h0C
`define RESET_DIR_BYTE    8'hFF
`define RESET_BYTE        8'h00
`define RESET_HALF        16'h0000

// =====================================================================
// timing: cycles after reset release during which the compare sample
// keeps tracking the inputs; the filter needs four edges to show the
// pins, so the fifth edge is the first that samples settled levels
`define INIT_SAMPLE_CYCLES 3'h5
`define INIT_COUNT_ZERO    3'h0
`define INIT_COUNT_ONE     3'h1
`endif

/* File: port_expander_pkg.sv */
package port_expander_pkg;
  // stored control bits of the device control register
  typedef struct packed {
    logic level1;      // extra output level, phase 1
    logic level0;      // extra output level, phase 0 / static
    logic alert_en;    // shared pin acts as change alert
    logic global_int;  // global intensity select
    logic blink_phase; // blink flip
    logic blink_en;    // blink enable
  } ctrl_type;

  // signals handed to the timing engine
  typedef struct packed {
    logic blink_en;    // blinking enabled
    logic blink_phase; // current phase (0 unless enabled)
    logic global_int;  // intensity from master register
  } engine_ctrl_type;
endpackage

/* File: input_sync.sv */
`timescale 1ns/1ps
`include "port_expander_consts.svh"
// =====================================================================
// three-flop input path; a change counts once stages two and three agree
module input_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // pins in, filtered level out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1_reg; // metastability catch, read only by stage2
  logic [WIDTH-1:0] stage2_reg; // second stage
  logic [WIDTH-1:0] stage3_reg; // third stage

  // shift chain
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // accept a bit only where the last two stages agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_out <= '0;
    end else begin
      level_out <= (stage2_reg & stage3_reg) | (level_out & (stage2_reg | stage3_reg));
    end
  end
endmodule // input_sync

/* File: port_expander_config_regs.sv */
`timescale 1ns/1ps
`include "port_expander_consts.svh"
module port_expander_config_regs
  import port_expander_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // register access from the serial slave
  input  wire logic            wr_en,
  input  wire logic [7:0]      wr_addr,
  input  wire logic [7:0]      wr_data,
  input  wire logic            rd_en,
  input  wire logic [7:0]      rd_addr,
  output logic      [7:0]      rd_data,
  output logic                 rd_valid,
  // input port register reads (refresh compare sample)
  input  wire logic            input_low_read,
  input  wire logic            input_high_read,
  // port pins as seen by the input buffers
  input  wire logic [15:0]     port_pin_in,
  // port directions and engine controls
  output logic      [15:0]     port_direction,
  output engine_ctrl_type      engine_ctrl,
  output logic                 change_detected,
  // shared alert / extra output pin, open drain
  input  wire logic            alert_pin_in,
  output logic                 alert_pin_out,
  output logic                 alert_pin_oe
);
  // =====================================================================
  // state
  ctrl_type    ctrl_reg;       // stored control bits
  logic [7:0]  dir_low_reg;    // ports 7..0 direction
  logic [7:0]  dir_high_reg;   // ports 15..8 direction
  logic [15:0] sample_reg;     // compare sample of inputs
  logic [15:0] level_sync;     // filtered pin levels
  logic        change_reg;     // change detected flag
  logic [2:0]  init_count_reg; // power-up sampling window
  logic        extra_level;    // selected extra output level
  logic        wr_ctrl;        // write to device control
  logic [15:0] mismatch;       // inputs differing from sample

  assign wr_ctrl  = wr_en && (wr_addr == `ADDR_DEV_CTRL);
  assign mismatch = (level_sync ^ sample_reg) & port_direction;

  // =====================================================================
  // pin filter
  input_sync #(.WIDTH(16)) u_input_sync (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (port_pin_in),
    .level_out (level_sync)
  );

  // =====================================================================
  // device control register; D7 and D6 writes are dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= ctrl_type'(`RESET_DEV_CTRL);
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_type'(wr_data[`BIT_LEVEL1:`BIT_BLINK_EN]);
    end
  end

  // =====================================================================
  // direction registers, 1 = input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir_low_reg  <= `RESET_DIR_BYTE;
      dir_high_reg <= `RESET_DIR_BYTE;
    end else if (wr_en) begin
      if (wr_addr == `ADDR_DIR_LOW) begin
        dir_low_reg <= wr_data;
      end
      if (wr_addr == `ADDR_DIR_HIGH) begin
        dir_high_reg <= wr_data;
      end
    end
  end

  // registered copy for the port drivers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_direction <= {`RESET_DIR_BYTE, `RESET_DIR_BYTE};
    end else begin
      port_direction <= {dir_high_reg, dir_low_reg};
    end
  end

  // =====================================================================
  // power-up window: the sample follows the pins until the filter settles,
  // so ports held at valid levels raise no change at power-up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_count_reg <= `INIT_SAMPLE_CYCLES;
    end else if (init_count_reg != `INIT_COUNT_ZERO) begin
      init_count_reg <= init_count_reg - `INIT_COUNT_ONE;
    end
  end

  // =====================================================================
  // compare sample; port reads refresh their byte, control writes both
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sample_reg <= `RESET_HALF;
    end else begin
      if (input_low_read || wr_ctrl || (init_count_reg != `INIT_COUNT_ZERO)) begin
        sample_reg[7:0] <= level_sync[7:0];
      end
      if (input_high_read || wr_ctrl || (init_count_reg != `INIT_COUNT_ZERO)) begin
        sample_reg[15:8] <= level_sync[15:8];
      end
    end
  end

  // level flag: clears by itself once inputs match the sample again;
  // a read of the port byte that holds the change ends it the same way.
  // held off during the power-up window, where the sample still lags
  // the filter by one edge and would flash a false alert
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      change_reg <= 1'b0;
    end else begin
      change_reg <= (|mismatch) && (init_count_reg == `INIT_COUNT_ZERO);
    end
  end

  assign change_detected = change_reg;

  // =====================================================================
  // controls for the timing engine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      engine_ctrl <= '0;
    end else begin
      engine_ctrl.blink_en    <= ctrl_reg.blink_en;
      engine_ctrl.blink_phase <= ctrl_reg.blink_en && ctrl_reg.blink_phase;
      engine_ctrl.global_int  <= ctrl_reg.global_int;
    end
  end

  // =====================================================================
  // shared pin: alert when enabled, else extra output levels
  assign extra_level = (ctrl_reg.blink_en && ctrl_reg.blink_phase) ? ctrl_reg.level1
                                                                   : ctrl_reg.level0;

  // open drain: only ever drives low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alert_pin_out <= 1'b0;
      alert_pin_oe  <= 1'b0;
    end else begin
      alert_pin_out <= 1'b0;
      if (ctrl_reg.alert_en) begin
        alert_pin_oe <= change_reg;
      end else begin
        alert_pin_oe <= !extra_level;
      end
    end
  end

  // =====================================================================
  // read port; unmapped addresses read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data  <= `RESET_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        case (rd_addr)
          `ADDR_DIR_LOW:  rd_data <= dir_low_reg;
          `ADDR_DIR_HIGH: rd_data <= dir_high_reg;
          `ADDR_DEV_CTRL: rd_data <= {change_reg, 1'b0, ctrl_reg};
          default:        rd_data <= `RESET_BYTE;
        endcase
      end
    end
  end

  // =====================================================================
  // assertions
  property p_ctrl_write;
    @(posedge clk) disable iff (reset)
    wr_ctrl |=> (ctrl_reg.blink_en == $past(wr_data[`BIT_BLINK_EN]))
                && (ctrl_reg.blink_phase == $past(wr_data[`BIT_BLINK_PHASE]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_static_level;
    @(posedge clk) disable iff (reset)
    (!ctrl_reg.alert_en && !ctrl_reg.blink_en && !wr_ctrl) |=> (alert_pin_oe == !ctrl_reg.level0);
  endproperty
  a_static_level: assert property (p_static_level) else $error("static extra output wrong");

  property p_phase0_level;
    @(posedge clk) disable iff (reset)
    (!ctrl_reg.alert_en && ctrl_reg.blink_en && !ctrl_reg.blink_phase) |=> (alert_pin_oe == !$past(ctrl_reg.level0));
  endproperty
  a_phase0_level: assert property (p_phase0_level) else $error("phase 0 extra output wrong");

  property p_phase1_level;
    @(posedge clk) disable iff (reset)
    (!ctrl_reg.alert_en && ctrl_reg.blink_en && ctrl_reg.blink_phase) |=> (alert_pin_oe == !$past(ctrl_reg.level1));
  endproperty
  a_phase1_level: assert property (p_phase1_level) else $error("phase 1 extra output wrong");

  property p_alert_pin;
    @(posedge clk) disable iff (reset)
    ctrl_reg.alert_en |=> (alert_pin_oe == $past(change_reg)) && !alert_pin_out;
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin does not follow change flag");

  property p_ctrl_read;
    @(posedge clk) disable iff (reset)
    (rd_en && rd_addr == `ADDR_DEV_CTRL) |=> rd_valid && !rd_data[`BIT_ZERO]
                                             && (rd_data[`BIT_CHANGE] == $past(change_reg));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read back wrong");

  property p_dir_write;
    @(posedge clk) disable iff (reset)
    (wr_en && wr_addr == `ADDR_DIR_HIGH) |=> ##1 (port_direction[15:8] == $past(wr_data, 2));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not applied");

  property p_dir_read;
    @(posedge clk) disable iff (reset)
    (rd_en && rd_addr == `ADDR_DIR_LOW) |=> (rd_data == $past(dir_low_reg));
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read back wrong");

  property p_sample_refresh;
    @(posedge clk) disable iff (reset)
    input_low_read |=> (sample_reg[7:0] == $past(level_sync[7:0]));
  endproperty
  a_sample_refresh: assert property (p_sample_refresh) else $error("sample not refreshed");

  c_change_seen:  cover property (@(posedge clk) disable iff (reset) $rose(change_reg));
  c_blink_phase1: cover property (@(posedge clk) disable iff (reset) engine_ctrl.blink_phase);
  c_extra_low:    cover property (@(posedge clk) disable iff (reset) !ctrl_reg.alert_en && alert_pin_oe);
endmodule // port_expander_config_regs

/* File: host_model.sv */
`timescale 1ns/1ps
// =====================================================================
// host side: issues register strobes the way the serial slave would
module host_model (
  // clock
  input  wire logic       clk,
  // register strobes
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            rd_en,
  output logic [7:0]      rd_addr,
  // answer from the block
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  // idle strobes from time zero
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end
  // one write, held over exactly one taking edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    // released lines show a changed pattern, not the old value
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  // one read; answer is taken one cycle after the strobe
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule // host_model

/* File: tb.sv */
`timescale 1ns/1ps
// =====================================================================
// bench: integer register model predicts every read and output
module tb import port_expander_pkg::*;;
  logic            clk, reset, wr_en, rd_en, rd_valid, v, change_detected;
  logic            input_low_read, input_high_read, alert_pin_in, alert_pin_out, alert_pin_oe;
  logic [7:0]      wr_addr, wr_data, rd_addr, rd_data, d, c;
  logic [15:0]     port_pin_in, port_direction;
  engine_ctrl_type engine_ctrl;
  int              n_errors = 0, num_checks = 0, cycles = 0, chg_m = 0;
  int              mem_m [256];  // register model, unmapped stays zero
  // open-drain wire with pull-up
  assign alert_pin_in = alert_pin_oe ? 1'b0 : 1'b1;
  port_expander_config_regs dut_u (.clk, .reset, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr,
    .rd_data, .rd_valid, .input_low_read, .input_high_read, .port_pin_in, .port_direction,
    .engine_ctrl, .change_detected, .alert_pin_in, .alert_pin_out, .alert_pin_oe);
  host_model host_u (.clk, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data, .rd_valid);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // write through the host and mirror it in the model
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    host_u.write(a, x);
    if (a == 8'h06 || a == 8'h07) mem_m[a] = x;
    if (a == 8'h0F) mem_m[a] = x & 8'h3F;
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.read(a, d, v);
    chk("rd_valid", 1'b1, v);
    chk("rd_data", (a == 8'h0F) ? {chg_m[0], 7'h00} | mem_m[a] : mem_m[a], d);
  endtask
  // shared pin with alert off: oe high pulls the pin low
  function automatic logic exp_oe(input logic [7:0] k);
    return (k[0] & k[1]) ? ~k[5] : ~k[4];
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    input_low_read = 1'b0;
    input_high_read = 1'b0;
    port_pin_in = 16'h0000;
    void'($urandom(83127));
    mem_m[6] = 8'hFF;
    mem_m[7] = 8'hFF;
    mem_m[15] = 8'h0C;
    port_pin_in <= 16'($urandom);
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    tick(2);
    chk("engine_ctrl", 3'b001, engine_ctrl);
    chk("port_direction", 16'hFFFF, port_direction);
    chk("alert_pin_out", 1'b0, alert_pin_out);
    rd(8'h0F);
    rd(8'h07);
    $display("test reset done");
    // every blink and level combination, alert bit D3 clear, D2/D6/D7 random
    for (int i = 0; i < 16; i++) begin
      c = (8'($urandom) & 8'hC4) | {2'b00, i[3:2], 2'b00, i[1:0]};
      wr(8'h0F, c);
      tick(2);
      chk("engine_ctrl", {c[0], c[0] & c[1], c[2]}, engine_ctrl);
      chk("alert_pin_oe", exp_oe(c), alert_pin_oe);
      rd(8'h0F);
    end
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      wr(8'(6 + i % 2), 8'($urandom));
      tick(1);
      chk("port_direction", {mem_m[7][7:0], mem_m[6][7:0]}, port_direction);
      rd(8'(6 + i % 2));
    end
    wr(8'h20, 8'h5A);
    rd(8'h20);
    $display("test direction done");
    wr(8'h07, 8'hFF);
    wr(8'h06, 8'h00);
    wr(8'h0F, 8'h08);
    // bit 0 is an output port and must not count
    @(posedge clk) port_pin_in <= port_pin_in ^ 16'h0201;
    tick(10);
    chg_m = 1;
    chk("change_detected", 1'b1, change_detected);
    chk("alert_pin_oe", 1'b1, alert_pin_oe);
    rd(8'h0F);
    @(posedge clk) port_pin_in <= port_pin_in ^ 16'h0200;
    tick(10);
    chg_m = 0;
    chk("change_detected", 1'b0, change_detected);
    chk("alert_pin_oe", 1'b0, alert_pin_oe);
    @(posedge clk) port_pin_in <= port_pin_in ^ 16'h0200;
    tick(10);
    @(posedge clk) input_low_read <= 1'b1;
    @(posedge clk) input_low_read <= 1'b0;
    tick(3);
    chk("change_detected", 1'b1, change_detected);
    @(posedge clk) input_high_read <= 1'b1;
    @(posedge clk) input_high_read <= 1'b0;
    tick(3);
    chk("change_detected", 1'b0, change_detected);
    $display("test change done");
    results();
  end
endmodule // tb
